// [shared/chan_cfg_pkg.sv]
package chan_cfg_pkg;

  // ----------------------------------------------------------------
  // Sizes and word layout
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 4;
  localparam int CFG_W = 16;
  localparam int CASCADE_BIT = 14;
  localparam int SEL_LSB = 12;
  localparam int FAST_OFF_BIT = 11;
  localparam int RES_BIT = 10;
  localparam int CONT_BIT = 7;
  localparam int WARN_BIT = 6;
  localparam int MODE_LSB = 4;
  localparam int WPU_BIT = 3;
  localparam int WPD_BIT = 2;
  // Bits 15 and 9:8 never store
  localparam logic [15:0] CFG_WRITE_MASK = 16'h7cff;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Supervisor step sizes in mV
  localparam logic [3:0] STEP_FINE_MV = 4'h4;
  localparam logic [3:0] STEP_COARSE_MV = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DAC_SERVO = 2'b00,
    DAC_OPEN = 2'b01,
    DAC_DIRECT = 2'b10,
    DAC_SOFT_HOLD = 2'b11
  } dac_mode_type;

  typedef enum logic [2:0] {
    TRIM_OFF = 3'b000,
    TRIM_SOFT = 3'b001,
    TRIM_SERVO = 3'b010,
    TRIM_HOLD = 3'b011,
    TRIM_DIRECT = 3'b100
  } trim_state_type;

  typedef struct packed {
    logic cascade;
    logic [1:0] sel;
    logic fast_off;
    logic res_low;
    logic cont;
    logic on_warn;
    dac_mode_type mode;
    logic wpu;
    logic wpd;
  } cfg_fields_type;

  typedef struct packed {
    logic on;
    logic rise_done;
    logic fault_off;
    logic seq_req;
    logic fault_retry;
    logic soft_done;
    logic at_target;
    logic ov_warn;
    logic uv_warn;
  } chan_status_type;

  typedef struct packed {
    logic connect;
    logic soft_req;
    logic servo;
    logic nominal;
    logic from_reg;
    logic write_ok;
    logic fast_servo;
  } dac_ctl_type;

  typedef struct packed {
    logic out;
    logic oe;
    logic enable_pin_weak_pullup;
    logic enable_pin_weak_pulldown;
  } pin_drive_type;

  // Splits a stored word into its fields
  function automatic cfg_fields_type decode_cfg(input logic [15:0] w);
    cfg_fields_type f;
    f.cascade = w[CASCADE_BIT];
    f.sel = w[SEL_LSB+:2];
    f.fast_off = w[FAST_OFF_BIT];
    f.res_low = w[RES_BIT];
    f.cont = w[CONT_BIT];
    f.on_warn = w[WARN_BIT];
    f.mode = dac_mode_type'(w[MODE_LSB+:2]);
    f.wpu = w[WPU_BIT];
    f.wpd = w[WPD_BIT];
    return f;
  endfunction : decode_cfg

endpackage : chan_cfg_pkg

// [hw/cfg_word_store.sv]
`timescale 1ns/1ps
module cfg_word_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_chan,
  input wire logic [15:0] wr_data,
  // Stored words
  output logic [chan_cfg_pkg::NUM_CHAN-1:0][15:0] words_q
);

  // ----------------------------------------------------------------
  // One word per channel
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < chan_cfg_pkg::NUM_CHAN; gi++)
  begin : g_word
    // Reserved bits are dropped on write
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        words_q[gi] <= chan_cfg_pkg::CFG_RESET;
      else if (wr_en && wr_chan == 2'(gi))
        words_q[gi] <= wr_data & chan_cfg_pkg::CFG_WRITE_MASK;
    end

    rsv_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (words_q[gi] & ~chan_cfg_pkg::CFG_WRITE_MASK) == 16'h0000)
      else $error("reserved config bits stored");
    own_word_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && wr_chan != 2'(gi)) |=> $stable(words_q[gi]))
      else $error("write to other channel changed this word");
  end

endmodule : cfg_word_store

// [hw/trim_dac_ctrl.sv]
`timescale 1ns/1ps
module trim_dac_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel settings and state
  input chan_cfg_pkg::cfg_fields_type cfg,
  input chan_cfg_pkg::chan_status_type stat,
  // Trim DAC controls
  output chan_cfg_pkg::dac_ctl_type ctl_q
);

  chan_cfg_pkg::trim_state_type state_q, state_d;
  chan_cfg_pkg::dac_mode_type mode_q;
  logic act;
  logic warn_hit;
  logic nom_q, nom_d;

  assign act = stat.on & stat.rise_done;
  assign warn_hit = stat.ov_warn | stat.uv_warn;

  // ----------------------------------------------------------------
  // Connection sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    nom_d = nom_q;
    if (!act || cfg.mode == chan_cfg_pkg::DAC_OPEN ||
        (state_q != chan_cfg_pkg::TRIM_OFF && cfg.mode != mode_q))
    begin
      state_d = chan_cfg_pkg::TRIM_OFF;
      nom_d = 1'b0;
    end
    else
      unique case (state_q)
        chan_cfg_pkg::TRIM_OFF:
          state_d = (cfg.mode == chan_cfg_pkg::DAC_DIRECT) ?
            chan_cfg_pkg::TRIM_DIRECT : chan_cfg_pkg::TRIM_SOFT;
        chan_cfg_pkg::TRIM_SOFT:
          if (stat.soft_done)
            state_d = (mode_q == chan_cfg_pkg::DAC_SERVO) ?
              chan_cfg_pkg::TRIM_SERVO : chan_cfg_pkg::TRIM_HOLD;
        chan_cfg_pkg::TRIM_SERVO:
          if (stat.at_target && !cfg.cont)
          begin
            state_d = chan_cfg_pkg::TRIM_HOLD;
            nom_d = 1'b0;
          end
        chan_cfg_pkg::TRIM_HOLD:
          if (mode_q == chan_cfg_pkg::DAC_SERVO && cfg.cont)
            state_d = chan_cfg_pkg::TRIM_SERVO;
          else if (mode_q == chan_cfg_pkg::DAC_SERVO && cfg.on_warn && warn_hit)
          begin
            state_d = chan_cfg_pkg::TRIM_SERVO;
            nom_d = 1'b1;
          end
        chan_cfg_pkg::TRIM_DIRECT:
          state_d = chan_cfg_pkg::TRIM_DIRECT;
        default:
          state_d = chan_cfg_pkg::TRIM_OFF;
      endcase
  end

  // State, entry mode and decoded outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= chan_cfg_pkg::TRIM_OFF;
      mode_q <= chan_cfg_pkg::DAC_SERVO;
      nom_q <= 1'b0;
      ctl_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      nom_q <= nom_d;
      if (state_q == chan_cfg_pkg::TRIM_OFF)
        mode_q <= cfg.mode;
      ctl_q.connect <= state_d != chan_cfg_pkg::TRIM_OFF;
      ctl_q.soft_req <= state_d == chan_cfg_pkg::TRIM_SOFT;
      ctl_q.servo <= state_d == chan_cfg_pkg::TRIM_SERVO;
      ctl_q.nominal <= nom_d;
      ctl_q.from_reg <= state_d == chan_cfg_pkg::TRIM_DIRECT;
      ctl_q.write_ok <= state_d == chan_cfg_pkg::TRIM_DIRECT ||
        (state_d == chan_cfg_pkg::TRIM_HOLD && cfg.mode == chan_cfg_pkg::DAC_SOFT_HOLD);
      ctl_q.fast_servo <= state_d == chan_cfg_pkg::TRIM_SERVO && !cfg.fast_off;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence hold_warn_s;
    state_q == chan_cfg_pkg::TRIM_HOLD && act && !cfg.cont &&
      mode_q == chan_cfg_pkg::DAC_SERVO && cfg.mode == chan_cfg_pkg::DAC_SERVO && warn_hit;
  endsequence

  idle_off_a: assert property (!act |=> !ctl_q.connect)
    else $error("trim DAC connected while channel not ready");
  open_mode_a: assert property (
    act && cfg.mode == chan_cfg_pkg::DAC_OPEN |=> !ctl_q.connect)
    else $error("trim DAC connected in open mode");
  direct_conn_a: assert property (act && cfg.mode == chan_cfg_pkg::DAC_DIRECT &&
    state_q == chan_cfg_pkg::TRIM_OFF |=> ctl_q.from_reg && !ctl_q.soft_req)
    else $error("direct mode did not connect at once");
  soft_write_a: assert property (ctl_q.soft_req |-> !ctl_q.write_ok ##1
    (ctl_q.soft_req || !ctl_q.write_ok || !$past(ctl_q.soft_req) || $past(stat.soft_done)))
    else $error("DAC write allowed before soft-connect done");
  warn_reservo_a: assert property (
    hold_warn_s ##0 cfg.on_warn |=> ctl_q.servo && ctl_q.nominal)
    else $error("no re-servo on warning");
  no_reservo_a: assert property (hold_warn_s ##0 !cfg.on_warn |=> !ctl_q.servo)
    else $error("re-servo while feature off");
  fast_servo_a: assert property (
    ctl_q.fast_servo |-> ctl_q.servo && !$past(cfg.fast_off))
    else $error("fast servo while disabled");

endmodule : trim_dac_ctrl

// [hw/channel_config_decode.sv]
`timescale 1ns/1ps
module channel_config_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration word access
  input wire logic cfg_wr_en,
  input wire logic [1:0] cfg_wr_chan,
  input wire logic [15:0] cfg_wr_data,
  input wire logic [1:0] cfg_rd_chan,
  output logic [15:0] cfg_rd_data_q,
  // Control input pins
  input wire logic control_input_zero,
  input wire logic control_input_one,
  input wire logic control_input_two,
  input wire logic control_input_three,
  // Channel state from the sequencer
  input chan_cfg_pkg::chan_status_type [chan_cfg_pkg::NUM_CHAN-1:0] chan_stat,
  // Sequencing decisions
  output logic [chan_cfg_pkg::NUM_CHAN-1:0] ctl_sel_q,
  output logic [chan_cfg_pkg::NUM_CHAN-1:0] chan_start_q,
  output logic [chan_cfg_pkg::NUM_CHAN-1:0] retry_ok_q,
  // Supervisor step size in mV
  output logic [chan_cfg_pkg::NUM_CHAN-1:0][3:0] sup_step_mv_q,
  // Trim DAC controls
  output chan_cfg_pkg::dac_ctl_type [chan_cfg_pkg::NUM_CHAN-1:0] dac_ctl_q,
  // Output-enable pin drivers
  output chan_cfg_pkg::pin_drive_type [chan_cfg_pkg::NUM_CHAN-1:0] pin_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [chan_cfg_pkg::NUM_CHAN-1:0][15:0] words;
  logic [3:0] ctl_pins;
  logic [3:0] ctl_meta_q;
  logic [3:0] ctl_sync_q;
  chan_cfg_pkg::cfg_fields_type [chan_cfg_pkg::NUM_CHAN-1:0] fields;

  assign ctl_pins = {control_input_three, control_input_two,
                     control_input_one, control_input_zero};

  // ----------------------------------------------------------------
  // Per-channel word storage
  // ----------------------------------------------------------------
  cfg_word_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(cfg_wr_en),
    .wr_chan(cfg_wr_chan),
    .wr_data(cfg_wr_data),
    .words_q(words)
  );

  // Read back of the addressed word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_rd_data_q <= 16'h0000;
    else
      cfg_rd_data_q <= words[cfg_rd_chan] & chan_cfg_pkg::CFG_WRITE_MASK;
  end

  // ----------------------------------------------------------------
  // Control pin synchronisers
  // ----------------------------------------------------------------
  for (genvar gp = 0; gp < 4; gp++)
  begin : g_sync
    // Two stages before any use
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ctl_meta_q[gp] <= 1'b0;
        ctl_sync_q[gp] <= 1'b0;
      end
      else
      begin
        ctl_meta_q[gp] <= ctl_pins[gp];
        ctl_sync_q[gp] <= ctl_meta_q[gp];
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel logic
  // ----------------------------------------------------------------
  for (genvar gc = 0; gc < chan_cfg_pkg::NUM_CHAN; gc++)
  begin : g_chan
    logic sel_lvl;
    chan_cfg_pkg::chan_status_type st;

    assign fields[gc] = chan_cfg_pkg::decode_cfg(words[gc]);
    assign sel_lvl = ctl_sync_q[fields[gc].sel];
    assign st = chan_stat[gc];

    // Selected control level
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        ctl_sel_q[gc] <= 1'b0;
      else
        ctl_sel_q[gc] <= sel_lvl;
    end

    // Start permission; in cascade, control only starts, never stops
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        chan_start_q[gc] <= 1'b0;
      else if (fields[gc].cascade)
        chan_start_q[gc] <= st.seq_req & (sel_lvl | st.on);
      else
        chan_start_q[gc] <= st.seq_req & sel_lvl;
    end

    // Fault retry permission
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        retry_ok_q[gc] <= 1'b0;
      else
        retry_ok_q[gc] <= st.fault_retry & (fields[gc].cascade | sel_lvl);
    end

    // Supervisor step size
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        sup_step_mv_q[gc] <= chan_cfg_pkg::STEP_FINE_MV;
      else
        sup_step_mv_q[gc] <= fields[gc].res_low ? chan_cfg_pkg::STEP_COARSE_MV :
          chan_cfg_pkg::STEP_FINE_MV;
    end

    // Output-enable pin driver
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        pin_q[gc] <= '{out: 1'b0, oe: 1'b1, enable_pin_weak_pullup: 1'b0,
                       enable_pin_weak_pulldown: 1'b0};
      else if (st.on)
        pin_q[gc] <= '{out: fields[gc].wpu, oe: fields[gc].wpu,
                       enable_pin_weak_pullup: fields[gc].wpu,
                       enable_pin_weak_pulldown: 1'b0};
      else if (!fields[gc].wpd || st.fault_off)
        pin_q[gc] <= '{out: 1'b0, oe: 1'b1, enable_pin_weak_pullup: 1'b0,
                       enable_pin_weak_pulldown: 1'b0};
      else
        pin_q[gc] <= '{out: 1'b0, oe: 1'b1, enable_pin_weak_pullup: 1'b0,
                       enable_pin_weak_pulldown: 1'b1};
    end

    // Trim DAC connection sequence
    trim_dac_ctrl u_trim (
      .clk(clk),
      .rst_n(rst_n),
      .cfg(fields[gc]),
      .stat(st),
      .ctl_q(dac_ctl_q[gc])
    );

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence cascade_wait_s;
      fields[gc].cascade && !sel_lvl && !st.on;
    endsequence

    sel_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      fields[gc].sel == 2'b11 |=> ctl_sel_q[gc] == $past(ctl_sync_q[3]))
      else $error("selected control input not followed");
    cascade_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
      cascade_wait_s |=> !chan_start_q[gc])
      else $error("cascade channel started without control input");
    cascade_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      fields[gc].cascade && st.on && st.seq_req |=> chan_start_q[gc])
      else $error("cascade control input turned channel off");
    retry_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      fields[gc].cascade && st.fault_retry |=> retry_ok_q[gc])
      else $error("cascade retry blocked");
    step_size_a: assert property (@(posedge clk) disable iff (!rst_n)
      fields[gc].res_low ##1 $stable(fields[gc].res_low) |->
        sup_step_mv_q[gc] == chan_cfg_pkg::STEP_COARSE_MV)
      else $error("wrong supervisor step");
    pull_up_a: assert property (@(posedge clk) disable iff (!rst_n)
      st.on |=> pin_q[gc].oe == $past(fields[gc].wpu) &&
        pin_q[gc].enable_pin_weak_pullup == $past(fields[gc].wpu))
      else $error("wrong pull-up while on");
    fast_pd_a: assert property (@(posedge clk) disable iff (!rst_n)
      !st.on && (!fields[gc].wpd || st.fault_off) |=>
        pin_q[gc].oe && !pin_q[gc].out && !pin_q[gc].enable_pin_weak_pulldown)
      else $error("fast pull-down missing");
    weak_pd_a: assert property (@(posedge clk) disable iff (!rst_n)
      !st.on && fields[gc].wpd && !st.fault_off |=>
        pin_q[gc].oe && pin_q[gc].enable_pin_weak_pulldown)
      else $error("weak pull-down missing on soft stop");
  end

  rd_rsv_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_rd_data_q[15] == 1'b0 && cfg_rd_data_q[9:8] == 2'b00)
    else $error("reserved bits read non-zero");
  rd_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr_en ##1 cfg_rd_chan == $past(cfg_wr_chan) |=>
      cfg_rd_data_q == ($past(cfg_wr_data, 2) & chan_cfg_pkg::CFG_WRITE_MASK))
    else $error("written word not read back");

endmodule : channel_config_decode

// [testbench/cfg_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the configuration word port
// ----------------------------------------------------------------
module cfg_host_model (
  // Clock
  input wire logic clk,
  // Write port
  output logic cfg_wr_en,
  output logic [1:0] cfg_wr_chan,
  output logic [15:0] cfg_wr_data,
  // Read select
  output logic [1:0] cfg_rd_chan
);
  // Idle bus at time zero
  initial
  begin
    cfg_wr_en = 1'b0;
    cfg_wr_chan = 2'h0;
    cfg_wr_data = 16'h0000;
    cfg_rd_chan = 2'h0;
  end

  // One whole word per write; back to back allowed
  task automatic write(input logic [1:0] c, input logic [15:0] d);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_chan <= c;
    cfg_wr_data <= d;
  endtask : write

  // Drop strobe; data lines no longer hold the last word
  task automatic idle();
    @(posedge clk);
    cfg_wr_en <= 1'b0;
    cfg_wr_chan <= ~cfg_wr_chan;
    cfg_wr_data <= ~cfg_wr_data;
  endtask : idle

  // Trim value is written by the host only after connect; no trim port here
  task automatic sel_read(input logic [1:0] c);
    @(posedge clk);
    cfg_rd_chan <= c;
  endtask : sel_read
endmodule : cfg_host_model

// [testbench/channel_config_decode_tb_top.sv]
`timescale 1ns/1ps
module channel_config_decode_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [8:0] S_ON = 9'h100;
  localparam logic [8:0] S_ACT = 9'h180;
  localparam logic [8:0] S_FO = 9'h040;
  localparam logic [8:0] S_SEQ = 9'h020;
  localparam logic [8:0] S_RTY = 9'h010;
  localparam logic [8:0] S_SD = 9'h008;
  localparam logic [8:0] S_AT = 9'h004;
  logic clk, rst_n, wr_en;
  logic [1:0] wr_chan, rd_chan;
  logic [15:0] wr_data, rd_data;
  logic [3:0] cin, ctl_sel, start, retry;
  logic [3:0][3:0] step;
  chan_cfg_pkg::chan_status_type [3:0] stat;
  chan_cfg_pkg::dac_ctl_type [3:0] dac;
  chan_cfg_pkg::pin_drive_type [3:0] pin;
  logic [15:0] w [4];
  logic fo, cont, warn;
  logic [3:0] pv;
  int failures = 0;
  int comparisons = 0;

  // Clock at 25 MHz
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  cfg_host_model u_host (.clk(clk), .cfg_wr_en(wr_en), .cfg_wr_chan(wr_chan),
    .cfg_wr_data(wr_data), .cfg_rd_chan(rd_chan));

  channel_config_decode u_dut (.clk(clk), .rst_n(rst_n), .cfg_wr_en(wr_en),
    .cfg_wr_chan(wr_chan), .cfg_wr_data(wr_data), .cfg_rd_chan(rd_chan),
    .cfg_rd_data_q(rd_data), .control_input_zero(cin[0]), .control_input_one(cin[1]),
    .control_input_two(cin[2]), .control_input_three(cin[3]), .chan_stat(stat),
    .ctl_sel_q(ctl_sel), .chan_start_q(start), .retry_ok_q(retry),
    .sup_step_mv_q(step), .dac_ctl_q(dac), .pin_q(pin));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally(input string n, input logic [15:0] e, input logic [15:0] g,
    input logic bad);
    comparisons++;
    if (bad)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : tally

  task automatic chk_bit(input string n, input logic e, input logic g);
    tally(n, {15'h0, e}, {15'h0, g}, g !== e);
  endtask : chk_bit

  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    tally(n, e, g, g !== e);
  endtask : chk_word

  task automatic chk_pin(input string n, input logic [3:0] e,
    input chan_cfg_pkg::pin_drive_type g);
    tally(n, {12'h0, e}, {12'h0, g}, g !== e);
  endtask : chk_pin

  // Expected read-back: reserved bits 15 and 9:8 read as zero
  function automatic logic [15:0] exp_word(input logic [15:0] d);
    return {1'h0, d[14:10], 2'h0, d[7:0]};
  endfunction : exp_word

  // Expected supervisor step from the resolution bit
  function automatic logic [15:0] exp_step(input logic [15:0] d);
    return {12'h0, (d[10] ? chan_cfg_pkg::STEP_COARSE_MV : chan_cfg_pkg::STEP_FINE_MV)};
  endfunction : exp_step

  // Expected pin drive {out, oe, weak up, weak down}
  function automatic logic [3:0] exp_pin(input logic on, input logic fault, input logic wpu,
    input logic wpd);
    if (on)
      return {wpu, wpu, wpu, 1'h0};
    return {1'h0, 1'h1, 1'h0, wpd & ~fault};
  endfunction : exp_pin

  task automatic st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : st

  task automatic cfg(input int c, input logic [15:0] d);
    u_host.write(2'(c), d);
    u_host.idle();
    st(3);
  endtask : cfg

  task automatic ss(input int c, input logic [8:0] v);
    @(posedge clk);
    stat[c] <= chan_cfg_pkg::chan_status_type'(v);
    st(3);
  endtask : ss

  task automatic rd(input int c);
    u_host.sel_read(2'(c));
    st(2);
  endtask : rd

  task automatic done(input string n);
    $display("Test %s finished, failures so far %0d", n, failures);
  endtask : done

  task automatic summarize();
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    cin = 4'h0;
    stat = '0;
    void'($urandom(24));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    st(2);
    for (int c = 0; c < 4; c++)
    begin
      rd(c);
      chk_word("reset word", 16'h0000, rd_data);
      chk_word("reset step", exp_step(16'h0000), {12'h0, step[c]});
      chk_pin("reset pin", exp_pin(1'h0, 1'h0, 1'h0, 1'h0), pin[c]);
    end
    done("reset");
    for (int c = 0; c < 4; c++)
    begin
      w[c] = (c == 3) ? 16'hffff : 16'($urandom);
      u_host.write(2'(c), w[c]);
    end
    u_host.idle();
    st(3);
    for (int c = 0; c < 4; c++)
    begin
      rd(c);
      chk_word("word", exp_word(w[c]), rd_data);
      chk_word("step", exp_step(w[c]), {12'h0, step[c]});
    end
    done("words");
    for (int s = 0; s < 4; s++)
    begin
      cfg(0, 16'(s) << 12);
      ss(0, S_SEQ | S_RTY);
      pv = 4'($urandom);
      for (int k = 0; k < 2; k++)
      begin
        @(posedge clk);
        cin <= (k == 0) ? pv : ~pv;
        st(5);
        chk_bit("sel level", cin[s], ctl_sel[0]);
        chk_bit("sel start", cin[s], start[0]);
        chk_bit("sel retry", cin[s], retry[0]);
      end
    end
    ss(0, 9'h000);
    done("select");
    cfg(1, 16'h6000);
    @(posedge clk);
    cin <= 4'h0;
    ss(1, S_SEQ | S_RTY);
    st(3);
    chk_bit("cascade wait", 1'b0, start[1]);
    chk_bit("cascade retry", 1'b1, retry[1]);
    @(posedge clk);
    cin <= 4'h4;
    st(5);
    chk_bit("cascade go", 1'b1, start[1]);
    ss(1, S_SEQ | S_RTY | S_ON);
    @(posedge clk);
    cin <= 4'h0;
    st(5);
    chk_bit("cascade no off", 1'b1, start[1]);
    ss(1, 9'h000);
    done("cascade");
    for (int m = 0; m < 4; m++)
    begin
      cfg(2, 16'(m) << 2);
      ss(2, S_ON);
      chk_pin("pin on", exp_pin(1'h1, 1'h0, m[1], m[0]), pin[2]);
      ss(2, 9'h000);
      chk_pin("pin soft off", exp_pin(1'h0, 1'h0, m[1], m[0]), pin[2]);
      ss(2, S_FO);
      chk_pin("pin fault off", exp_pin(1'h0, 1'h1, m[1], m[0]), pin[2]);
    end
    done("pins");
    cfg(3, 16'h0010);
    ss(3, S_ACT);
    chk_word("mode open", 16'h0000, {9'h0, dac[3]});
    ss(3, 9'h000);
    cfg(3, 16'h0020);
    ss(3, S_ACT);
    chk_bit("direct connect", 1'b1, dac[3].connect);
    chk_bit("direct reg", 1'b1, dac[3].from_reg);
    chk_bit("direct write", 1'b1, dac[3].write_ok);
    chk_bit("direct soft", 1'b0, dac[3].soft_req);
    ss(3, S_ON);
    chk_bit("rise pending", 1'b0, dac[3].connect);
    ss(3, 9'h000);
    cfg(3, 16'h0030);
    ss(3, S_ACT);
    chk_bit("hold soft", 1'b1, dac[3].soft_req);
    chk_bit("hold early", 1'b0, dac[3].write_ok);
    ss(3, S_ACT | S_SD);
    chk_bit("hold soft end", 1'b0, dac[3].soft_req);
    chk_bit("hold write", 1'b1, dac[3].write_ok);
    ss(3, 9'h000);
    for (int v = 0; v < 3; v++)
    begin
      fo = (v != 0);
      cont = (v == 2);
      warn = (v != 1);
      cfg(3, {4'h0, fo, 3'h0, cont, warn, 6'h00});
      ss(3, S_ACT);
      chk_bit("servo soft", 1'b1, dac[3].soft_req);
      ss(3, S_ACT | S_SD);
      chk_bit("servo run", 1'b1, dac[3].servo);
      chk_bit("servo fast", ~fo, dac[3].fast_servo);
      ss(3, S_ACT | S_SD | S_AT);
      chk_bit("servo target", cont, dac[3].servo);
      ss(3, S_ACT | S_SD | ((v == 0) ? 9'h002 : 9'h001));
      chk_bit("servo warn", cont | warn, dac[3].servo);
      if (!cont)
        chk_bit("servo nominal", warn, dac[3].nominal);
      ss(3, 9'h000);
      chk_bit("servo off", 1'b0, dac[3].connect);
    end
    done("trim");
    summarize();
  end
endmodule : channel_config_decode_tb_top
